// ===== rtccal_counts.sv
`timescale 1ns/1ps

// Operation
// - bcd hours: tens 0-2 upper nibble, ones 0-9 lower, 24-hour count
// - binary hours: whole byte holds 0 to 23
// - weekday counts from one, values one to seven
// - weekday upper nibble reserved, read-only, zero after reset
// - bcd day of month: tens 0-3, ones 0-9
// - day of month starts at one; binary at most 31
// - month: bcd tens 0-1 ones 0-9; binary 1 to 12
// - bcd year: two decimal digits, each 0-9
// - binary year: whole byte 0 to 99
// - bcd century: two decimal digits, each 0-9
// - binary century: whole byte 0 to 99
// - locked: writes ignored, reads served; unlocked: reads and writes
// - reset leaves all count values untouched
// - format bit: clear is binary, set is packed bcd
// - unlock bit set halts counting and opens writes; clear runs
// - reset comes up locked, counting enabled
// - month lengths and leap years tracked only in bcd format
module rtccal_counts (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic [7:0] io_addr,
    input  wire logic       io_wr,
    input  wire logic       io_rd,
    input  wire logic [7:0] io_wdata,
    input  wire logic       bcd_sel,
    input  wire logic       unlock_set,
    input  wire logic       unlock_clr,
    input  wire logic       hour_carry,
    output logic      [7:0] io_rdata,
    output logic            io_hit,
    output logic            unlock,
    output logic      [7:0] hour_count,
    output logic      [7:0] weekday_count,
    output logic      [7:0] day_in_month_count,
    output logic      [7:0] calendar_period_count,
    output logic      [7:0] year_count,
    output logic      [7:0] hundreds_of_years_count
);

    ////////////////////////////////////////////////////////////////////////
    // state

    // stored fields; the count bytes carry no reset
    logic [7:0] hour_q;
    logic [3:0] weekday_value_q;
    logic [3:0] weekday_rsv_q;
    logic [7:0] day_q;
    logic [7:0] period_q;
    logic [7:0] year_q;
    logic [7:0] hundred_q;
    logic       unlock_q;
    logic [7:0] rdata_q;
    logic       hit_q;

    // next values and wrap flags from the incrementers
    logic [7:0] hour_d;
    logic [7:0] wday_d;
    logic [7:0] day_d;
    logic [7:0] period_d;
    logic [7:0] year_d;
    logic [7:0] hundred_d;
    logic       hour_wrap;
    logic       wday_wrap;
    logic       day_wrap;
    logic       period_wrap;
    logic       year_wrap;
    logic       hundred_wrap;
    // month length limit, the count strobe gated from hour_carry and the bus write strobe
    logic [7:0] day_last;
    logic       tick;
    logic       wr_ok;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // packed bcd byte to binary, used for month and year decoding
    // digits above nine are not trapped; they give an out-of-range result
    function automatic logic [7:0] bcd2bin(input logic [7:0] v);
        logic [7:0] t;
        t = {4'h0, v[rtccal_pkg::TENS_MSB:rtccal_pkg::TENS_LSB]};
        return 8'((t << 3) + (t << 1)) + {4'h0, v[rtccal_pkg::ONES_MSB:rtccal_pkg::ONES_LSB]};
    endfunction : bcd2bin

    // pick the binary or bcd form of a limit
    function automatic logic [7:0] lim(input logic bcd, input logic [7:0] b,
                                       input logic [7:0] d);
        return bcd ? d : b;
    endfunction : lim

    ////////////////////////////////////////////////////////////////////////
    // last day of the current month

    // binary format has no month table, so every month runs to 31
    // leap test looks at the two year digits only; century years are not special
    always_comb begin
        logic [7:0] m;
        logic [7:0] y;
        m = bcd2bin(period_q);
        y = bcd2bin(year_q);
        day_last = rtccal_pkg::DAY_MAX_BCD;
        if (!bcd_sel) begin
            day_last = rtccal_pkg::DAY_MAX_BIN;
        end else if (period_q == rtccal_pkg::FEB_BCD) begin
            // february runs to the 29th when the year divides by four
            if (y[1:0] == 2'b00) begin
                day_last = rtccal_pkg::FEB_LEAP_BCD;
            end else begin
                day_last = rtccal_pkg::FEB_LAST_BCD;
            end
        end else if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h0b) begin
            day_last = rtccal_pkg::SHORT_LAST_BCD;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // field incrementers

    // hours wrap after 23 in either encoding
    rtccal_digit u_hour (
        .cur  (hour_q),
        .bcd  (bcd_sel),
        .lo   (rtccal_pkg::HOUR_MIN),
        .hi   (lim(bcd_sel, rtccal_pkg::HOUR_MAX_BIN, rtccal_pkg::HOUR_MAX_BCD)),
        .nxt  (hour_d),
        .wrap (hour_wrap)
    );

    // weekday is one to seven in both formats
    rtccal_digit u_wday (
        .cur  ({4'h0, weekday_value_q}),
        .bcd  (bcd_sel),
        .lo   (rtccal_pkg::WEEKDAY_MIN),
        .hi   (rtccal_pkg::WEEKDAY_MAX),
        .nxt  (wday_d),
        .wrap (wday_wrap)
    );

    // day limit follows the month table in bcd
    rtccal_digit u_day (
        .cur  (day_q),
        .bcd  (bcd_sel),
        .lo   (rtccal_pkg::DAY_MIN),
        .hi   (day_last),
        .nxt  (day_d),
        .wrap (day_wrap)
    );

    // month runs from one to twelve
    rtccal_digit u_period (
        .cur  (period_q),
        .bcd  (bcd_sel),
        .lo   (rtccal_pkg::PERIOD_MIN),
        .hi   (lim(bcd_sel, rtccal_pkg::PERIOD_MAX_BIN, rtccal_pkg::PERIOD_MAX_BCD)),
        .nxt  (period_d),
        .wrap (period_wrap)
    );

    // year runs from zero to 99
    rtccal_digit u_year (
        .cur  (year_q),
        .bcd  (bcd_sel),
        .lo   (rtccal_pkg::YEAR_MIN),
        .hi   (lim(bcd_sel, rtccal_pkg::YEAR_MAX_BIN, rtccal_pkg::YEAR_MAX_BCD)),
        .nxt  (year_d),
        .wrap (year_wrap)
    );

    // century shares the year limits; its carry out goes nowhere
    rtccal_digit u_hundred (
        .cur  (hundred_q),
        .bcd  (bcd_sel),
        .lo   (rtccal_pkg::YEAR_MIN),
        .hi   (lim(bcd_sel, rtccal_pkg::YEAR_MAX_BIN, rtccal_pkg::YEAR_MAX_BCD)),
        .nxt  (hundred_d),
        .wrap (hundred_wrap)
    );

    ////////////////////////////////////////////////////////////////////////
    // lock control

    // counting runs only while locked; a set and clear together keeps lock
    assign tick  = hour_carry && !unlock_q;
    assign wr_ok = io_wr && unlock_q;

    // lock state; clear is tested first so it wins over a set
    always_ff @(posedge mclk) begin
        if (rst) begin
            unlock_q <= rtccal_pkg::UNLOCK_RST;
        end else if (unlock_clr) begin
            unlock_q <= 1'b0;
        end else if (unlock_set) begin
            unlock_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // count registers, untouched by reset except the reserved weekday nibble
    // writes need unlock and ticks need lock, so the two never meet

    // hours: 0-23 binary or 00-23 bcd, carry feeds day and weekday
    always_ff @(posedge mclk) begin
        if (wr_ok && io_addr == rtccal_pkg::HOUR_OFS) begin
            hour_q <= io_wdata;
        end else if (tick) begin
            hour_q <= hour_d;
        end
    end

    // weekday value bits; only the low nibble is writable
    always_ff @(posedge mclk) begin
        if (wr_ok && io_addr == rtccal_pkg::WEEKDAY_OFS) begin
            weekday_value_q <= io_wdata[3:0];
        end else if (tick && hour_wrap) begin
            weekday_value_q <= wday_d[3:0];
        end
    end

    // reserved nibble is the only part cleared by reset
    // kept as a flop so the read mux and the output share one source
    always_ff @(posedge mclk) begin
        if (rst) begin
            weekday_rsv_q <= rtccal_pkg::WEEKDAY_RSV_RST;
        end
    end

    // day of month wraps to one and advances the month
    always_ff @(posedge mclk) begin
        if (wr_ok && io_addr == rtccal_pkg::DAY_OFS) begin
            day_q <= io_wdata;
        end else if (tick && hour_wrap) begin
            day_q <= day_d;
        end
    end

    // month wraps to one and advances the year
    always_ff @(posedge mclk) begin
        if (wr_ok && io_addr == rtccal_pkg::PERIOD_OFS) begin
            period_q <= io_wdata;
        end else if (tick && hour_wrap && day_wrap) begin
            period_q <= period_d;
        end
    end

    // year wraps to zero and advances the century
    always_ff @(posedge mclk) begin
        if (wr_ok && io_addr == rtccal_pkg::YEAR_OFS) begin
            year_q <= io_wdata;
        end else if (tick && hour_wrap && day_wrap && period_wrap) begin
            year_q <= year_d;
        end
    end

    // century has no carry out; it simply wraps after 99
    always_ff @(posedge mclk) begin
        if (wr_ok && io_addr == rtccal_pkg::HUNDRED_OFS) begin
            hundred_q <= io_wdata;
        end else if (tick && hour_wrap && day_wrap && period_wrap && year_wrap) begin
            hundred_q <= hundred_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read port, served whether locked or not

    // read data is registered so every output comes from a flop
    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata_q <= 8'h00;
            hit_q   <= 1'b0;
        end else begin
            hit_q <= 1'b0;
            if (io_rd) begin
                hit_q <= 1'b1;
                case (io_addr)
                    rtccal_pkg::HOUR_OFS:    rdata_q <= hour_q;
                    rtccal_pkg::WEEKDAY_OFS: rdata_q <= {weekday_rsv_q, weekday_value_q};
                    rtccal_pkg::DAY_OFS:     rdata_q <= day_q;
                    rtccal_pkg::PERIOD_OFS:  rdata_q <= period_q;
                    rtccal_pkg::YEAR_OFS:    rdata_q <= year_q;
                    rtccal_pkg::HUNDRED_OFS: rdata_q <= hundred_q;
                    default: begin
                        rdata_q <= 8'h00; // not ours
                        hit_q   <= 1'b0;
                    end
                endcase
            end
        end
    end

    // outputs straight from flip-flops
    assign io_rdata                = rdata_q;
    assign io_hit                  = hit_q;
    assign unlock                  = unlock_q;
    assign hour_count              = hour_q;
    assign weekday_count           = {weekday_rsv_q, weekday_value_q};
    assign day_in_month_count      = day_q;
    assign calendar_period_count   = period_q;
    assign year_count              = year_q;
    assign hundreds_of_years_count = hundred_q;

endmodule : rtccal_counts

// ===== rtccal_pkg.sv
package rtccal_pkg;

    // register offsets on the processor i/o bus
    localparam logic [7:0] HOUR_OFS      = 8'he2;
    localparam logic [7:0] WEEKDAY_OFS   = 8'he3;
    localparam logic [7:0] DAY_OFS       = 8'he4;
    localparam logic [7:0] PERIOD_OFS    = 8'he5;
    localparam logic [7:0] YEAR_OFS      = 8'he6;
    localparam logic [7:0] HUNDRED_OFS   = 8'he7;

    // field layout of a packed bcd byte
    localparam int TENS_MSB = 7;
    localparam int TENS_LSB = 4;
    localparam int ONES_MSB = 3;
    localparam int ONES_LSB = 0;

    // reserved upper nibble of the weekday register after reset
    localparam logic [3:0] WEEKDAY_RSV_RST = 4'h0;

    // lock state after reset: counting on, registers read-only
    localparam logic UNLOCK_RST = 1'b0;

    // binary limits of each count
    localparam logic [7:0] HOUR_MAX_BIN    = 8'h17;
    localparam logic [7:0] WEEKDAY_MIN     = 8'h01;
    localparam logic [7:0] WEEKDAY_MAX     = 8'h07;
    localparam logic [7:0] DAY_MIN         = 8'h01;
    localparam logic [7:0] DAY_MAX_BIN     = 8'h1f;
    localparam logic [7:0] PERIOD_MIN      = 8'h01;
    localparam logic [7:0] PERIOD_MAX_BIN  = 8'h0c;
    localparam logic [7:0] YEAR_MAX_BIN    = 8'h63;

    // bcd limits of each count
    localparam logic [7:0] HOUR_MAX_BCD    = 8'h23;
    localparam logic [7:0] PERIOD_MAX_BCD  = 8'h12;
    localparam logic [7:0] YEAR_MAX_BCD    = 8'h99;
    localparam logic [7:0] FEB_BCD         = 8'h02;

    // bcd month lengths and the zero floors of the counts
    localparam logic [7:0] DAY_MAX_BCD     = 8'h31;
    localparam logic [7:0] SHORT_LAST_BCD  = 8'h30;
    localparam logic [7:0] FEB_LEAP_BCD    = 8'h29;
    localparam logic [7:0] FEB_LAST_BCD    = 8'h28;
    localparam logic [7:0] HOUR_MIN        = 8'h00;
    localparam logic [7:0] YEAR_MIN        = 8'h00;

endpackage : rtccal_pkg

// ===== rtccal_digit.sv
`timescale 1ns/1ps

// one calendar field: advance with wrap, in binary or packed bcd
module rtccal_digit (
    input  wire logic [7:0] cur,
    input  wire logic       bcd,
    input  wire logic [7:0] lo,
    input  wire logic [7:0] hi,
    output logic      [7:0] nxt,
    output logic            wrap
);

    // increment one step; bcd adjusts the ones digit past nine
    always_comb begin
        wrap = (cur == hi);
        if (wrap) begin
            nxt = lo;
        end else if (bcd && (cur[3:0] == 4'h9)) begin
            nxt = {cur[7:4] + 4'h1, 4'h0};
        end else begin
            nxt = cur + 8'h01;
        end
    end

endmodule : rtccal_digit

// ===== rtccal_counts_checker.sv
`timescale 1ns/1ps

module rtccal_counts_checker (
    input wire logic       mclk,
    input wire logic       rst,
    input wire logic [7:0] io_addr,
    input wire logic       io_wr,
    input wire logic       io_rd,
    input wire logic [7:0] io_wdata,
    input wire logic       bcd_sel,
    input wire logic       unlock_set,
    input wire logic       unlock_clr,
    input wire logic       hour_carry,
    input wire logic [7:0] io_rdata,
    input wire logic       io_hit,
    input wire logic       unlock,
    input wire logic [7:0] hour_count,
    input wire logic [7:0] weekday_count,
    input wire logic [7:0] day_in_month_count,
    input wire logic [7:0] year_count
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    // reads of our six offsets or of any other, a counted carry, a locked write
    sequence s_rd_ours;
        io_rd && io_addr >= 8'he2 && io_addr <= 8'he7;
    endsequence
    sequence s_rd_other;
        io_rd && (io_addr < 8'he2 || io_addr > 8'he7);
    endsequence
    sequence s_quiet_tick;
        !unlock && hour_carry && !io_wr;
    endsequence
    sequence s_locked_wr;
        !unlock && io_wr && !hour_carry;
    endsequence

    chk_hit_on_read: assert property (s_rd_ours |=> io_hit)
        else $error("read of a count register gave no hit");
    chk_unmapped_miss: assert property (s_rd_other |=> !io_hit && io_rdata == 8'h00)
        else $error("unmapped read answered");
    chk_read_hour: assert property (io_rd && io_addr == 8'he2
        |=> io_rdata == $past(hour_count))
        else $error("hour read data wrong");
    chk_locked_wr_drop: assert property (s_locked_wr
        |=> $stable(hour_count) && $stable(day_in_month_count) && $stable(year_count))
        else $error("write landed while locked");
    chk_write_lands: assert property (unlock && io_wr && io_addr == 8'he6
        |=> year_count == $past(io_wdata))
        else $error("unlocked year write lost");
    chk_weekday_rsv: assert property (weekday_count[7:4] == 4'h0)
        else $error("weekday reserved bits set");
    chk_reset_locked: assert property ($fell(rst) |-> !unlock)
        else $error("not locked after reset");
    chk_unlock_halts: assert property (unlock && hour_carry && !io_wr
        |=> $stable(hour_count) && $stable(weekday_count))
        else $error("counted while unlocked");
    chk_hour_wrap_bin: assert property (s_quiet_tick
        ##0 (!bcd_sel && hour_count == 8'h17)
        |=> hour_count == 8'h00 && $changed(weekday_count))
        else $error("binary hour wrap wrong");
    chk_hour_wrap_bcd: assert property (s_quiet_tick
        ##0 (bcd_sel && hour_count == 8'h23)
        |=> hour_count == 8'h00 && $changed(day_in_month_count))
        else $error("bcd hour wrap wrong");
    chk_clear_wins: assert property (unlock_set && unlock_clr |=> !unlock)
        else $error("lock clear lost to set");
    chk_unlock_sets: assert property (unlock_set && !unlock_clr |=> unlock)
        else $error("unlock request ignored");
endmodule : rtccal_counts_checker

bind rtccal_counts rtccal_counts_checker u_chk (.mclk, .rst, .io_addr, .io_wr, .io_rd,
    .io_wdata, .bcd_sel, .unlock_set, .unlock_clr, .hour_carry, .io_rdata, .io_hit, .unlock,
    .hour_count, .weekday_count, .day_in_month_count, .year_count);

// ===== rtccal_counts_tb.sv
`timescale 1ns/1ps

module rtccal_counts_tb;
    logic       mclk = 1'b0;
    logic       rst = 1'b1;
    logic [7:0] io_addr = 8'h00;
    logic       io_wr = 1'b0;
    logic       io_rd = 1'b0;
    logic [7:0] io_wdata = 8'h00;
    logic       bcd_sel = 1'b0;
    logic       unlock_set = 1'b0;
    logic       unlock_clr = 1'b0;
    logic       hour_carry = 1'b0;
    logic [7:0] io_rdata, hour_count, weekday_count, day_in_month_count;
    logic [7:0] calendar_period_count, year_count, hundreds_of_years_count;
    logic       io_hit, unlock;
    int         fail_count = 0;
    int         checked = 0;

    always #5 mclk = ~mclk;

    rtccal_counts dut (.mclk, .rst, .io_addr, .io_wr, .io_rd, .io_wdata, .bcd_sel,
        .unlock_set, .unlock_clr, .hour_carry, .io_rdata, .io_hit, .unlock, .hour_count,
        .weekday_count, .day_in_month_count, .calendar_period_count, .year_count,
        .hundreds_of_years_count);

    ////////////////////////////////////////////////////////////////////////////////
    task check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check

    task print_verdict;
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict

    // each access holds its strobe for exactly one sampling edge
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk) begin io_addr <= a; io_wdata <= d; io_wr <= 1'b1; end
        @(posedge mclk) io_wr <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, input logic [7:0] exp, input logic hit);
        @(posedge mclk) begin io_addr <= a; io_rd <= 1'b1; end
        @(posedge mclk) io_rd <= 1'b0;
        #1 check({7'h00, io_hit}, {7'h00, hit});
        check(io_rdata, exp);
    endtask : rd

    task lock_ctl(input logic s, input logic c);
        @(posedge mclk) begin unlock_set <= s; unlock_clr <= c; end
        @(posedge mclk) begin unlock_set <= 1'b0; unlock_clr <= 1'b0; end
    endtask : lock_ctl

    task tick;
        @(posedge mclk) hour_carry <= 1'b1;
        @(posedge mclk) hour_carry <= 1'b0;
        #1;
    endtask : tick

    // writes all six counts with the clock unlocked, then locks again
    task load(input logic [7:0] h, w, d, m, y, c);
        lock_ctl(1'b1, 1'b0);
        wr(8'he2, h); wr(8'he3, w); wr(8'he4, d);
        wr(8'he5, m); wr(8'he6, y); wr(8'he7, c);
        lock_ctl(1'b0, 1'b1);
    endtask : load

    task cmp(input logic [7:0] h, w, d, m, y, c);
        check(hour_count, h); check(weekday_count, w); check(day_in_month_count, d);
        check(calendar_period_count, m); check(year_count, y);
        check(hundreds_of_years_count, c);
    endtask : cmp

    ////////////////////////////////////////////////////////////////////////////////
    // watchdog: a hang counts as a mismatch
    initial begin
        repeat (5000) @(posedge mclk);
        fail_count++;
        print_verdict();
    end

    initial begin
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk) #1;
        check({7'h00, unlock}, 8'h00);
        check(weekday_count & 8'hf0, 8'h00);
        load(8'h17, 8'hf7, 8'h1f, 8'h0c, 8'h63, 8'h05);
        rd(8'he3, 8'h07, 1'b1);
        rd(8'he8, 8'h00, 1'b0);
        wr(8'he2, 8'h05);
        rd(8'he2, 8'h17, 1'b1);
        tick();
        cmp(8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h06);
        rd(8'he7, 8'h06, 1'b1);
        // binary keeps no month table, so february runs on past 28
        load(8'h17, 8'h03, 8'h1c, 8'h02, 8'h00, 8'h06);
        tick();
        cmp(8'h00, 8'h04, 8'h1d, 8'h02, 8'h00, 8'h06);
        lock_ctl(1'b1, 1'b0);
        tick();
        check(hour_count, 8'h00);
        lock_ctl(1'b1, 1'b1);
        #1 check({7'h00, unlock}, 8'h00);
        @(posedge mclk) bcd_sel <= 1'b1;
        load(8'h09, 8'h07, 8'h28, 8'h02, 8'h23, 8'h20);
        tick();
        cmp(8'h10, 8'h07, 8'h28, 8'h02, 8'h23, 8'h20);
        load(8'h23, 8'h07, 8'h28, 8'h02, 8'h23, 8'h20);
        tick();
        cmp(8'h00, 8'h01, 8'h01, 8'h03, 8'h23, 8'h20);
        load(8'h23, 8'h01, 8'h28, 8'h02, 8'h24, 8'h20);
        tick();
        cmp(8'h00, 8'h02, 8'h29, 8'h02, 8'h24, 8'h20);
        // a thirty-day month in bcd rolls over after the 30th
        load(8'h23, 8'h02, 8'h30, 8'h04, 8'h24, 8'h20);
        tick();
        cmp(8'h00, 8'h03, 8'h01, 8'h05, 8'h24, 8'h20);
        load(8'h23, 8'h06, 8'h31, 8'h12, 8'h99, 8'h20);
        tick();
        cmp(8'h00, 8'h07, 8'h01, 8'h01, 8'h00, 8'h21);
        rd(8'he4, 8'h01, 1'b1);
        rd(8'he5, 8'h01, 1'b1);
        rd(8'he6, 8'h00, 1'b1);
        rd(8'he7, 8'h21, 1'b1);
        // second reset in mid-run, taken while unlocked, must keep the calendar
        lock_ctl(1'b1, 1'b0);
        @(posedge mclk) rst <= 1'b1;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk) #1;
        cmp(8'h00, 8'h07, 8'h01, 8'h01, 8'h00, 8'h21);
        check({7'h00, unlock}, 8'h00);
        check(weekday_count & 8'hf0, 8'h00);
        print_verdict();
    end
endmodule : rtccal_counts_tb
